//--- hdl/regfile_if.sv
`timescale 1ns/1ps
`include "vliw_defines.svh"

interface regfile_if #(
	parameter int NREG  = `REG_COUNT,
	parameter int WIDTH = `INSTR_W,
	parameter int NWR   = `WR_PORTS
);
	logic [NWR-1:0]                    we;
	logic [NWR-1:0][$clog2(NREG)-1:0]  waddr;
	logic [NWR-1:0][WIDTH-1:0]         wdata;
	logic [NREG-1:0][WIDTH-1:0]        rd;

	modport file (input we, input waddr, input wdata, output rd);
	modport core (output we, output waddr, output wdata, input rd);
endinterface

//--- hdl/side_regfile.sv
`timescale 1ns/1ps
`include "vliw_defines.svh"

module side_regfile #(
	parameter int NREG  = `REG_COUNT,
	parameter int WIDTH = `INSTR_W,
	parameter int NWR   = `WR_PORTS
)(
	// Clock and reset
	input  wire logic   mclk,
	input  wire logic   sys_rst,
	// Port bundle toward the core
	regfile_if.file     rf
);

	typedef struct packed {
		logic [NREG-1:0][WIDTH-1:0] regs;
	} rf_state_t;

	rf_state_t state_reg;
	rf_state_t state_next;

	// Higher port wins, so a returning load beats a unit result
	always_comb
	begin
		state_next = state_reg;
		for (int w = 0; w < NWR; w++)
		begin
			if (rf.we[w])
				state_next.regs[rf.waddr[w]] = rf.wdata[w];
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign rf.rd = state_reg.regs;

endmodule

//--- hdl/vliw_defines.svh
`ifndef VLIW_DEFINES_SVH
`define VLIW_DEFINES_SVH

`define SLOT_COUNT    8
`define INSTR_W       32
`define FETCH_W       256
`define FETCH_STRIDE  32'h0000_0020
`define RESET_PC      32'h0000_0000
`define REG_COUNT     16
`define REG_AW        4
`define WR_PORTS      6
`define WR_LOAD_BASE  4
`define CIRC_BITS     8
`define NOP_MASK      32'hFFFF_FFFE
`define LONG_BASE     4'hE

`define F_CHAIN       0
`define F_SIDE        1
`define F_UNIT        3:2
`define F_OP          6:4
`define F_CROSS       7
`define F_SRC1        11:8
`define F_SRC2        15:12
`define F_DST         19:16
`define F_CIRC        20
`define F_LONG        21
`define F_OFS5        27:23
`define F_ZERO        28
`define F_CREG        31:29
`define F_CREG_SIDE   31
`define F_CREG_IDX    30:29
`define F_DSTORE      4
`define F_DWIDTH      6:5
`define F_MUNSIGNED   4
`define F_MHIGH       5

`define OP_L_ADD      3'h0
`define OP_L_SUB      3'h1
`define OP_L_AND      3'h2
`define OP_L_OR       3'h3
`define OP_L_XOR      3'h4
`define OP_L_CMPEQ    3'h5
`define OP_L_CMPLT    3'h6
`define OP_S_SHL      3'h0
`define OP_S_SHR      3'h1
`define OP_S_SAR      3'h2
`define OP_S_ADD      3'h3
`define OP_S_SUB      3'h4
`define OP_S_AND      3'h5
`define OP_S_OR       3'h6
`define OP_S_BRANCH   3'h7

`define W_BYTE        2'h0
`define W_HALF        2'h1
`define W_WORD        2'h2
`define W_ADDA        2'h3
`define BE_BYTE       4'h1
`define BE_HALF_LO    4'h3
`define BE_HALF_HI    4'hC
`define BE_WORD       4'hF

`endif

//--- hdl/vliw_fetch_dispatch.sv
// Operation
// - fetch 256-bit packets of eight instructions
// - low bit one chains next instruction
// - low bit zero closes the execute packet
// - one to eight instructions issue together
// - one to eight execute packets per fetch
// - one execute packet per clock while dispatching, none while fetching
// - next fetch only after full dispatch
// - packets never span fetch packets; nops inert
// - two sixteen-entry 32-bit register files
// - four units per side use own file
// - one cross read per side per cycle; a second one still reads and sets xpath_conflict
// - address units move data, either file
// - linear or circular, 5/15-bit offsets
// - every instruction conditional on a register; a zero F_CREG field executes unconditionally
// - multiply units multiply; others arithmetic, branch
// - arithmetic uses registers only, never memory
// - byte, half-word and word loads, stores
`timescale 1ns/1ps
`include "vliw_defines.svh"

module vliw_fetch_dispatch #(
	parameter int CIRC_BITS = `CIRC_BITS
)(
	// Clock and reset
	input  wire logic                          mclk,
	input  wire logic                          sys_rst,
	// Program memory
	output logic                               fetch_req,
	output logic [31:0]                        fetch_addr,
	input  wire logic                          fetch_valid,
	input  wire logic [`FETCH_W-1:0]           fetch_data,
	// Dispatch status
	output logic                               issue_valid,
	output logic [`SLOT_COUNT-1:0]             issue_mask,
	output logic [7:0]                         unit_active,
	// Data memory, one port per address unit
	output logic [1:0]                         dmem_req,
	output logic [1:0]                         dmem_we,
	output logic [1:0][31:0]                   dmem_addr,
	output logic [1:0][3:0]                    dmem_be,
	output logic [1:0][31:0]                   dmem_wdata,
	input  wire logic [1:0][31:0]              dmem_rdata,
	// Error flags
	output logic                               xpath_conflict,
	output logic                               unit_conflict,
	output logic                               span_error
);

	vliw_pkg::core_state_t state_reg;
	vliw_pkg::core_state_t state_next;

	logic [1:0][`REG_COUNT-1:0][31:0]          regs_v;
	logic [1:0][`WR_PORTS-1:0]                 wr_en;
	logic [1:0][`WR_PORTS-1:0][`REG_AW-1:0]    wr_addr;
	logic [1:0][`WR_PORTS-1:0][31:0]           wr_data;

	logic [`INSTR_W-1:0]   ins;
	logic                  side;
	logic                  xside;
	logic [1:0]            unit;
	logic [2:0]            op;
	logic [31:0]           cval;
	logic                  cond;
	logic [31:0]           opa;
	logic [31:0]           opb;
	logic [31:0]           res;
	logic                  res_we;
	logic [15:0]           mul_a;
	logic [15:0]           mul_b;
	logic [31:0]           base;
	logic [31:0]           ofs;
	logic [31:0]           lin;
	logic [31:0]           eaddr;
	logic [31:0]           sdata;
	logic [1:0]            dwidth;
	logic [1:0]            xused;
	logic                  closed;
	logic [2:0]            last;

	// Both side files, one per generate pass
	regfile_if #(.NREG(`REG_COUNT), .WIDTH(`INSTR_W), .NWR(`WR_PORTS))
		rf_if [2] ();

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : gen_side
			side_regfile #(
				.NREG  (`REG_COUNT),
				.WIDTH (`INSTR_W),
				.NWR   (`WR_PORTS)
			) u_rf (
				.mclk    (mclk),
				.sys_rst (sys_rst),
				.rf      (rf_if[g].file)
			);
			assign rf_if[g].we    = wr_en[g];
			assign rf_if[g].waddr = wr_addr[g];
			assign rf_if[g].wdata = wr_data[g];
			assign regs_v[g]      = rf_if[g].rd;
		end
	endgenerate

	function automatic logic [31:0] load_extract(
		input logic [31:0] word,
		input logic [1:0]  width,
		input logic [1:0]  lane
	);
		logic [31:0] sh;
		sh = word >> {lane, 3'h0};
		case (width)
			`W_BYTE: load_extract = {{24{sh[7]}}, sh[7:0]};
			`W_HALF: load_extract = {{16{sh[15]}}, sh[15:0]};
			default: load_extract = sh;
		endcase
	endfunction

	always_comb
	begin
		state_next = state_reg;
		wr_en = '0;
		wr_addr = '0;
		wr_data = '0;
		ins = '0;
		side = 1'b0;
		xside = 1'b0;
		unit = 2'h0;
		op = 3'h0;
		cval = '0;
		cond = 1'b0;
		opa = '0;
		opb = '0;
		res = '0;
		res_we = 1'b0;
		mul_a = '0;
		mul_b = '0;
		base = '0;
		ofs = '0;
		lin = '0;
		eaddr = '0;
		sdata = '0;
		dwidth = `W_BYTE;
		xused = '0;
		closed = 1'b0;
		last = 3'(`SLOT_COUNT - 1);
		state_next.issue_valid = 1'b0;
		state_next.issue_mask = '0;
		state_next.unit_active = '0;
		state_next.dmem_req = '0;
		state_next.dmem_we = '0;
		state_next.xpath_conflict = 1'b0;
		state_next.unit_conflict = 1'b0;
		state_next.span_error = 1'b0;
		for (int a = 0; a < 2; a++)
			state_next.load[a].valid = 1'b0;

		// Load data lands one cycle after the request
		for (int a = 0; a < 2; a++)
		begin
			if (state_reg.load[a].valid)
			begin
				wr_en[state_reg.load[a].side][`WR_LOAD_BASE + a] = 1'b1;
				wr_addr[state_reg.load[a].side][`WR_LOAD_BASE + a] =
					state_reg.load[a].dst;
				wr_data[state_reg.load[a].side][`WR_LOAD_BASE + a] =
					load_extract(dmem_rdata[a], state_reg.load[a].width,
						state_reg.load[a].lane);
			end
		end

		case (state_reg.state)
			vliw_pkg::ST_FETCH:
			begin
				state_next.fetch_req = 1'b1;
				if (state_reg.fetch_req && fetch_valid)
				begin
					state_next.packet = fetch_data;
					state_next.ptr = '0;
					state_next.fetch_req = 1'b0;
					state_next.state = vliw_pkg::ST_DISPATCH;
				end
			end
			vliw_pkg::ST_DISPATCH:
			begin
				for (int i = 0; i < `SLOT_COUNT; i++)
				begin
					ins = state_reg.packet[i*`INSTR_W +: `INSTR_W];
					if (!closed && 3'(i) >= state_reg.ptr)
					begin
						state_next.issue_mask[i] = 1'b1;
						if (!ins[`F_CHAIN])
						begin
							closed = 1'b1;
							last = 3'(i);
						end
						// Nops occupy a slot but touch nothing
						if ((ins & `NOP_MASK) != '0)
						begin
							side = ins[`F_SIDE];
							xside = side ^ ins[`F_CROSS];
							unit = ins[`F_UNIT];
							op = ins[`F_OP];
							res_we = 1'b0;
							cval = regs_v[ins[`F_CREG_SIDE]]
								[{2'h0, ins[`F_CREG_IDX]}];
							cond = (ins[`F_CREG] == '0) ||
								(ins[`F_ZERO] ? (cval == '0)
									: (cval != '0));
							opa = regs_v[side][ins[`F_SRC1]];
							opb = regs_v[xside][ins[`F_SRC2]];
							if (ins[`F_CROSS])
							begin
								// Second cross read on a side is flagged
								if (xused[side])
									state_next.xpath_conflict = 1'b1;
								xused[side] = 1'b1;
							end
							if (state_next.unit_active[{side, unit}])
								state_next.unit_conflict = 1'b1;
							state_next.unit_active[{side, unit}] = 1'b1;
							if (cond)
							begin
								case (vliw_pkg::unit_t'(unit))
									vliw_pkg::UNIT_LOGIC:
									begin
										res_we = 1'b1;
										case (op)
											`OP_L_ADD: res = opa + opb;
											`OP_L_SUB: res = opa - opb;
											`OP_L_AND: res = opa & opb;
											`OP_L_OR: res = opa | opb;
											`OP_L_XOR: res = opa ^ opb;
											`OP_L_CMPEQ: res = {31'h0, opa == opb};
											`OP_L_CMPLT: res = {31'h0,
												$signed(opa) < $signed(opb)};
											default: res = opb;
										endcase
									end
									vliw_pkg::UNIT_SHIFT:
									begin
										res_we = (op != `OP_S_BRANCH);
										case (op)
											`OP_S_SHL: res = opa << opb[4:0];
											`OP_S_SHR: res = opa >> opb[4:0];
											`OP_S_SAR: res = $signed(opa) >>> opb[4:0];
											`OP_S_ADD: res = opa + opb;
											`OP_S_SUB: res = opa - opb;
											`OP_S_AND: res = opa & opb;
											`OP_S_OR: res = opa | opb;
											default:
											begin
												// Taken at the next fetch boundary
												state_next.branch_pend = 1'b1;
												state_next.branch_pc = opb;
											end
										endcase
									end
									vliw_pkg::UNIT_MUL:
									begin
										res_we = 1'b1;
										mul_a = ins[`F_MHIGH] ? opa[31:16] : opa[15:0];
										mul_b = ins[`F_MHIGH] ? opb[31:16] : opb[15:0];
										if (ins[`F_MUNSIGNED])
											res = {16'h0, mul_a} * {16'h0, mul_b};
										else
											res = {{16{mul_a[15]}}, mul_a} *
												{{16{mul_b[15]}}, mul_b};
									end
									default:
									begin
										dwidth = ins[`F_DWIDTH];
										if (ins[`F_LONG])
										begin
											base = regs_v[side][`LONG_BASE];
											ofs = {17'h0, ins[`F_OFS5], ins[22],
												ins[`F_SRC2], ins[`F_SRC1],
												ins[`F_CROSS]};
										end
										else
										begin
											base = regs_v[side][ins[`F_SRC2]];
											ofs = {27'h0, ins[`F_OFS5]};
										end
										if (dwidth != `W_ADDA)
											ofs = ofs << dwidth;
										lin = base + ofs;
										// Circular keeps the block, wraps inside it
										eaddr = ins[`F_CIRC] ?
											{base[31:CIRC_BITS], lin[CIRC_BITS-1:0]}
											: lin;
										sdata = regs_v[xside][ins[`F_DST]];
										if (dwidth == `W_ADDA)
										begin
											res_we = 1'b1;
											res = eaddr;
										end
										else
										begin
											state_next.dmem_req[side] = 1'b1;
											state_next.dmem_addr[side] =
												{eaddr[31:2], 2'h0};
											state_next.dmem_we[side] = ins[`F_DSTORE];
											case (dwidth)
												`W_BYTE:
												begin
													state_next.dmem_be[side] =
														`BE_BYTE << eaddr[1:0];
													state_next.dmem_wdata[side] =
														{4{sdata[7:0]}};
												end
												`W_HALF:
												begin
													state_next.dmem_be[side] = eaddr[1]
														? `BE_HALF_HI : `BE_HALF_LO;
													state_next.dmem_wdata[side] =
														{2{sdata[15:0]}};
												end
												default:
												begin
													state_next.dmem_be[side] = `BE_WORD;
													state_next.dmem_wdata[side] = sdata;
												end
											endcase
											if (!ins[`F_DSTORE])
												state_next.load[side] = '{valid: 1'b1,
													width: dwidth, lane: eaddr[1:0],
													side: xside,
													dst: ins[`F_DST]};
										end
									end
								endcase
								if (res_we)
								begin
									wr_en[side][unit] = 1'b1;
									wr_addr[side][unit] = ins[`F_DST];
									wr_data[side][unit] = res;
								end
							end
						end
					end
				end
				// All chained slots go out this cycle
				state_next.issue_valid = 1'b1;
				state_next.span_error = !closed;
				if (last == 3'(`SLOT_COUNT - 1))
				begin
					state_next.state = vliw_pkg::ST_FETCH;
					state_next.fetch_req = 1'b1;
					// Target read before the pending flag is dropped
					state_next.pc = state_next.branch_pend ?
						state_next.branch_pc
						: state_reg.pc + `FETCH_STRIDE;
					state_next.branch_pend = 1'b0;
				end
				else
				begin
					state_next.ptr = last + 3'h1;
					state_next.fetch_req = 1'b0;
				end
			end
			default:
				state_next.state = vliw_pkg::ST_FETCH;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			state_reg <= '0;
			state_reg.state <= vliw_pkg::ST_FETCH;
			state_reg.pc <= `RESET_PC;
		end
		else
			state_reg <= state_next;
	end

	assign fetch_req = state_reg.fetch_req;
	assign fetch_addr = state_reg.pc;
	assign issue_valid = state_reg.issue_valid;
	assign issue_mask = state_reg.issue_mask;
	assign unit_active = state_reg.unit_active;
	assign dmem_req = state_reg.dmem_req;
	assign dmem_we = state_reg.dmem_we;
	assign dmem_addr = state_reg.dmem_addr;
	assign dmem_be = state_reg.dmem_be;
	assign dmem_wdata = state_reg.dmem_wdata;
	assign xpath_conflict = state_reg.xpath_conflict;
	assign unit_conflict = state_reg.unit_conflict;
	assign span_error = state_reg.span_error;

endmodule

//--- hdl/vliw_pkg.sv
`include "vliw_defines.svh"

package vliw_pkg;

	typedef enum logic [1:0] {UNIT_LOGIC, UNIT_SHIFT, UNIT_MUL, UNIT_ADDR} unit_t;

	typedef enum logic {ST_FETCH, ST_DISPATCH} fetch_state_t;

	typedef struct packed {
		logic                  valid;
		logic [1:0]            width;
		logic [1:0]            lane;
		logic                  side;
		logic [`REG_AW-1:0]    dst;
	} load_pend_t;

	typedef struct packed {
		fetch_state_t          state;
		logic [31:0]           pc;
		logic [31:0]           branch_pc;
		logic                  branch_pend;
		logic [`FETCH_W-1:0]   packet;
		logic [2:0]            ptr;
		logic                  fetch_req;
		logic                  issue_valid;
		logic [`SLOT_COUNT-1:0] issue_mask;
		logic [7:0]            unit_active;
		logic [1:0]            dmem_req;
		logic [1:0]            dmem_we;
		logic [1:0][31:0]      dmem_addr;
		logic [1:0][31:0]      dmem_wdata;
		logic [1:0][3:0]       dmem_be;
		load_pend_t [1:0]      load;
		logic                  xpath_conflict;
		logic                  unit_conflict;
		logic                  span_error;
	} core_state_t;

endpackage

//--- test/prog_mem_model.sv
`timescale 1ns/1ps
`include "vliw_defines.svh"

module prog_mem_model (
	// Clock
	input  wire logic                mclk,
	// Fetch port
	input  wire logic                fetch_req,
	input  wire logic [31:0]         fetch_addr,
	output logic                     fetch_valid,
	output logic [`FETCH_W-1:0]      fetch_data,
	// Behaviour
	input  wire logic [3:0]          lag,
	input  wire logic [7:0]          n_pkts
);
	logic [`FETCH_W-1:0] mem [64];
	int                  wait_cnt = 0;
	int                  served = 0;

	initial
	begin
		fetch_valid = 1'b0;
		fetch_data = '0;
	end

	always @(posedge mclk)
	begin
		#1;
		// Idle data toggles so a stale packet never looks valid
		fetch_data = ~fetch_data;
		if (fetch_valid)
		begin
			fetch_valid = 1'b0;
			wait_cnt = 0;
			served++;
		end
		else if (fetch_req && served < n_pkts)
		begin
			if (wait_cnt >= lag)
			begin
				fetch_valid = 1'b1;
				fetch_data = mem[fetch_addr[10:5]];
			end
			else
				wait_cnt++;
		end
	end
endmodule

//--- test/vliw_fetch_dispatch_bench.sv
`timescale 1ns/1ps
`include "vliw_defines.svh"

module vliw_fetch_dispatch_bench;
	localparam int NPKT = 40;
	typedef struct packed {
		logic [68:0] mem;
		logic [1:0]  dreq;
		logic [1:0]  conf;
		logic [7:0]  unit;
		logic        span;
		logic [7:0]  mask;
	} exp_t;
	logic                  mclk;
	logic                  sys_rst;
	logic                  fetch_req;
	logic [31:0]           fetch_addr;
	logic                  fetch_valid;
	logic [`FETCH_W-1:0]   fetch_data;
	logic                  issue_valid;
	logic [7:0]            issue_mask;
	logic [7:0]            unit_active;
	logic [1:0]            dmem_req;
	logic [1:0]            dmem_we;
	logic [1:0][31:0]      dmem_addr;
	logic [1:0][3:0]       dmem_be;
	logic [1:0][31:0]      dmem_wdata;
	logic [1:0][31:0]      dmem_rdata;
	logic                  xpath_conflict;
	logic                  unit_conflict;
	logic                  span_error;
	logic [3:0]            lag;
	int                    mismatches = 0;
	int                    n_compared = 0;
	int                    n_acc = 0;
	exp_t                  exp_q[$];
	exp_t                  e;
	logic [68:0]           got;

	vliw_fetch_dispatch i_vliw_fetch_dispatch (.mclk(mclk), .sys_rst(sys_rst),
		.fetch_req(fetch_req), .fetch_addr(fetch_addr),
		.fetch_valid(fetch_valid), .fetch_data(fetch_data),
		.issue_valid(issue_valid), .issue_mask(issue_mask),
		.unit_active(unit_active), .dmem_req(dmem_req), .dmem_we(dmem_we),
		.dmem_addr(dmem_addr), .dmem_be(dmem_be), .dmem_wdata(dmem_wdata),
		.dmem_rdata(dmem_rdata), .xpath_conflict(xpath_conflict),
		.unit_conflict(unit_conflict), .span_error(span_error));

	prog_mem_model i_prog_mem_model (.mclk(mclk), .fetch_req(fetch_req),
		.fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
		.fetch_data(fetch_data), .lag(lag), .n_pkts(8'(NPKT)));

	task automatic check(input logic ok, input string msg);
		n_compared++;
		if (ok !== 1'b1)
		begin
			mismatches++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	task automatic tally_and_finish();
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Nop slots: only the chain bit is set
	function automatic logic [255:0] mk_pkt(input logic [7:0] chain);
		logic [255:0] p;
		p = '0;
		for (int s = 0; s < 8; s++)
			p[32*s] = chain[s];
		return p;
	endfunction

	function automatic logic [31:0] mk_ins(input logic ch, input logic sd,
		input logic [1:0] un, input logic [2:0] op, input logic cr,
		input logic [3:0] s2, input logic [3:0] d, input logic [4:0] o);
		logic [31:0] w;
		w = '0;
		w[`F_CHAIN] = ch;
		w[`F_SIDE] = sd;
		w[`F_UNIT] = un;
		w[`F_OP] = op;
		w[`F_CROSS] = cr;
		w[`F_SRC2] = s2;
		w[`F_DST] = d;
		w[`F_OFS5] = o;
		return w;
	endfunction

	function automatic void push_pkt(input logic [7:0] mask,
		input logic span, input logic [7:0] unit, input logic [1:0] dreq,
		input logic [1:0] conf, input logic [68:0] mem);
		exp_q.push_back({mem, dreq, conf, unit, span, mask});
	endfunction

	// Span flag only on the packet that slot 7 ends while chained
	function automatic void push_exp(input logic [7:0] chain);
		logic [7:0] m;
		m = 8'h00;
		for (int s = 0; s < 8; s++)
		begin
			m[s] = 1'b1;
			if (!chain[s] || s == 7)
			begin
				push_pkt(m, chain[s], 8'h00, 2'h0, 2'h0, '0);
				m = 8'h00;
			end
		end
	endfunction

	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	initial
	begin
		#200000;
		mismatches++;
		tally_and_finish();
	end

	always @(negedge mclk)
	begin
		if (!sys_rst && fetch_req && fetch_valid)
		begin
			check(fetch_addr === 32'(n_acc) * 32'h0000_0020, "address");
			n_acc++;
		end
		if (!sys_rst && issue_valid === 1'b1)
		begin
			e = (exp_q.size() != 0) ? exp_q.pop_front() : '0;
			got = {dmem_we[e.dreq[1]], dmem_be[e.dreq[1]],
				dmem_wdata[e.dreq[1]], dmem_addr[e.dreq[1]]};
			check(issue_mask === e.mask, "packet mask");
			check(span_error === e.span, "span flag");
			check(unit_active === e.unit && dmem_req === e.dreq, "units");
			check({xpath_conflict, unit_conflict} === e.conf, "conflicts");
			if (e.dreq != 2'h0)
				check(got === e.mem, "store");
		end
	end

	initial
	begin
		logic [7:0] ch;
		logic [255:0] dp;
		sys_rst = 1'b1;
		lag = 4'h0;
		dmem_rdata = '0;
		void'($urandom(63400));
		// Eight singles, one full packet, one packet spanning the boundary
		// Last packet is a small real program
		for (int k = 0; k < NPKT; k++)
		begin
			if (k == NPKT - 1)
			begin
				// Address-add, half store, doubled cross add, cross byte
				// store, then a store whose condition fails
				dp = '0;
				dp[0 +: 32] = mk_ins(1'b0, 1'b0, 2'h3, {`W_ADDA, 1'b0},
					1'b0, 4'h0, 4'h1, 5'h13);
				dp[32 +: 32] = mk_ins(1'b0, 1'b0, 2'h3, {`W_HALF, 1'b1},
					1'b0, 4'h1, 4'h1, 5'h02);
				dp[64 +: 32] = mk_ins(1'b1, 1'b1, 2'h0, `OP_L_ADD,
					1'b1, 4'h0, 4'h2, 5'h00);
				dp[96 +: 32] = mk_ins(1'b0, 1'b1, 2'h0, `OP_L_ADD,
					1'b1, 4'h0, 4'h2, 5'h00);
				dp[128 +: 32] = mk_ins(1'b0, 1'b1, 2'h3, {`W_BYTE, 1'b1},
					1'b1, 4'h0, 4'h1, 5'h07);
				dp[160 +: 32] = mk_ins(1'b0, 1'b0, 2'h3, {`W_BYTE, 1'b1},
					1'b0, 4'h1, 4'h1, 5'h02) | 32'h3000_0000;
				i_prog_mem_model.mem[k] = dp;
				push_pkt(8'h01, 1'b0, 8'h08, 2'h0, 2'h0, '0);
				push_pkt(8'h02, 1'b0, 8'h08, 2'h1, 2'h0, {1'b1,
					`BE_HALF_HI, 32'h0013_0013, 32'h0000_0014});
				push_pkt(8'h0C, 1'b0, 8'h10, 2'h0, 2'h3, '0);
				push_pkt(8'h10, 1'b0, 8'h80, 2'h2, 2'h0, {1'b1,
					4'h8, 32'h1313_1313, 32'h0000_0004});
				push_pkt(8'h20, 1'b0, 8'h08, 2'h0, 2'h0, '0);
				push_pkt(8'h40, 1'b0, 8'h00, 2'h0, 2'h0, '0);
				push_pkt(8'h80, 1'b0, 8'h00, 2'h0, 2'h0, '0);
			end
			else
			begin
				ch = (k == 0) ? 8'h00 : (k == 1) ? 8'h7F : (k == 2) ? 8'hFF
					: 8'($urandom);
				i_prog_mem_model.mem[k] = mk_pkt(ch);
				push_exp(ch);
			end
		end
		repeat (3) @(posedge mclk);
		#1 sys_rst = 1'b0;
		for (int t = 0; t < 4000 && exp_q.size() != 0; t++)
		begin
			@(posedge mclk);
			#1 lag = 4'($urandom_range(0, 3));
			dmem_rdata = {$urandom, $urandom};
		end
		check(exp_q.size() == 0, "packets missing");
		check(n_acc == NPKT, "fetch count");
		sys_rst = 1'b1;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		check(fetch_req === 1'b0 && fetch_addr === 32'h0000_0000
			&& issue_valid === 1'b0 && dmem_req === 2'h0, "reset");
		tally_and_finish();
	end
endmodule

bind vliw_fetch_dispatch vliw_fetch_dispatch_props i_vliw_fetch_dispatch_props (
	.mclk(mclk), .sys_rst(sys_rst), .fetch_req(fetch_req),
	.fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
	.fetch_data(fetch_data), .issue_valid(issue_valid),
	.issue_mask(issue_mask), .dmem_req(dmem_req), .span_error(span_error));

//--- test/vliw_fetch_dispatch_props.sv
`timescale 1ns/1ps
`include "vliw_defines.svh"

module vliw_fetch_dispatch_props (
	// Clock and reset
	input wire logic                mclk,
	input wire logic                sys_rst,
	// Program memory
	input wire logic                fetch_req,
	input wire logic [31:0]         fetch_addr,
	input wire logic                fetch_valid,
	input wire logic [`FETCH_W-1:0] fetch_data,
	// Dispatch
	input wire logic                issue_valid,
	input wire logic [`SLOT_COUNT-1:0] issue_mask,
	input wire logic [1:0]          dmem_req,
	input wire logic                span_error
);
	logic [7:0] chain_reg;
	logic [7:0] chain_next;
	logic [7:0] top_next;
	logic [7:0] inner;

	// Chain bits of the packet now being dispatched
	always_comb
	begin
		chain_next = chain_reg;
		if (fetch_req && fetch_valid)
			for (int s = 0; s < 8; s++)
				chain_next[s] = fetch_data[32*s];
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			chain_reg <= 8'h00;
		else
			chain_reg <= chain_next;
	end

	// Bit just above the packet; wraps to zero for the last packet
	assign top_next = issue_mask + (issue_mask & (~issue_mask + 8'h01));
	assign inner    = issue_mask & (issue_mask >> 1);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	AST_REQ_HOLD: assert property (fetch_req && !fetch_valid |=>
		fetch_req && $stable(fetch_addr))
		else $error("fetch request dropped before acceptance");
	AST_ALIGN: assert property (fetch_req |-> fetch_addr[4:0] == 5'h00)
		else $error("fetch address not packet aligned");
	AST_ACCEPT: assert property (fetch_req && fetch_valid |=>
		!fetch_req ##1 (issue_valid && issue_mask[0]))
		else $error("first packet not from slot 0 two cycles on");
	AST_NO_REQ_MID: assert property (issue_valid && !issue_mask[7] |->
		!fetch_req)
		else $error("fetch requested while packets remain");
	AST_REQ_LAST: assert property (issue_valid && issue_mask[7] |->
		fetch_req)
		else $error("no fetch request with the last packet");
	AST_BACK2BACK: assert property (issue_valid && !issue_mask[7] |=>
		issue_valid)
		else $error("gap between execute packets");
	AST_CONTIG: assert property (issue_valid |-> issue_mask != 8'h00 &&
		(top_next & issue_mask) == 8'h00)
		else $error("execute packet not contiguous");
	AST_ASCEND: assert property (issue_valid && !issue_mask[7] |=>
		(issue_mask & (~issue_mask + 8'h01)) == $past(top_next))
		else $error("next packet does not follow the previous one");
	AST_CHAINED: assert property (issue_valid |->
		(chain_reg & inner) == inner)
		else $error("unchained slot inside a packet");
	AST_BREAK: assert property (issue_valid |->
		(chain_reg & issue_mask & ~inner & 8'h7F) == 8'h00)
		else $error("packet ends on a chained slot");
	AST_SPAN: assert property (issue_valid && issue_mask[7] |->
		span_error == chain_reg[7])
		else $error("span flag wrong on last packet");
	AST_DMEM_ISSUE: assert property (dmem_req != 2'h0 |-> issue_valid)
		else $error("memory access outside an issue");
endmodule
